//--- src/tas_top.sv
// Chosen here: the AHB-Lite register port.
`timescale 1ns/10ps
`include "tas_defines.svh"

// Functional notes
// - Period is (multiplier plus one) times 2 us.
// - Rate counter advances per period, reads live.
// - Any write to rate counter clears it.
// - First-stage trigger clears the rate counter.
// - Sample budget sets count; zero means unlimited.
// - Packet: timestamp, encoders, digital port, analog.
// - Every sample packet is pushed to FIFO.
// - First stage loads remaining from budget.
// - After second stage, remaining decrements per period.
// - Remaining at zero stops and clears enable.
// - Zero budget loads all ones, never decrements.
// - Start is OR of four trigger sources.
// - Digital trigger needs first then second stage.
// - Analog and pulse-width thresholds also start.
// - Encoder events start, enabled per channel.
// - Single-stage sources set both stage bits.
// - While running, event triggers ignored until disabled.
// - Second-stage trigger only acts after first stage.
// - Continuous bit is second stage and zero budget.
// - Control bits 4 to 7 enable encoders 0-3.
module tas_top
(
	input  wire logic                                     hclk,
	input  wire logic                                     hresetn,
	input  wire logic                                     hsel,
	input  wire logic [31:0]                              haddr,
	input  wire logic [1:0]                               htrans,
	input  wire logic                                     hwrite,
	input  wire logic [2:0]                               hsize,
	input  wire logic [31:0]                              hwdata,
	input  wire logic                                     hready,
	output logic                                          hreadyout,
	output logic                                          hresp,
	output logic [31:0]                                   hrdata,
	input  wire logic                                     first_stage_trigger,
	input  wire logic                                     second_stage_trigger,
	input  wire logic                                     adc_trigger,
	input  wire logic                                     pwm_trigger,
	input  wire logic [`TAS_CHANNELS-1:0]                 encoder_event,
	input  wire logic [`TAS_CHANNELS-1:0][31:0]           encoder_data,
	input  wire logic [`TAS_DIN_W-1:0]                    digital_in,
	input  wire logic [`TAS_CHANNELS-1:0][`TAS_ADC_W-1:0] adc_data,
	output logic                                          packet_push,
	output logic [31:0]                                   packet_timestamp,
	output logic [`TAS_CHANNELS-1:0][31:0]                packet_encoder,
	output logic [`TAS_DIN_W-1:0]                         packet_digital,
	output logic [`TAS_CHANNELS-1:0][`TAS_ADC_W-1:0]      packet_adc
);

	localparam int                         tick_cycles = `TAS_TICK_CYCLES;
	localparam logic [`TAS_TICK_CNT_W-1:0] tick_last   = `TAS_TICK_CNT_W'(`TAS_TICK_CYCLES - 1);

	tas_pkg::tas_state_type st;
	tas_pkg::tas_state_type next_st;

	logic                  base_tick;
	logic                  period_tick;
	logic                  single_src;
	logic                  accept;
	logic [`TAS_IDX_W-1:0] addr_idx;

	////////////////////////////////////////////////////////////////////////////////

	// Addresses beyond the register page map to an unused index so they read zero.
	function automatic logic [`TAS_IDX_W-1:0] word_index(input logic [31:0] addr);
		word_index = (addr[31:8] == 24'h00_0000) ? addr[7:2] : `TAS_IDX_NONE;
	endfunction

	function automatic logic [31:0] read_word(input tas_pkg::tas_state_type s, input logic [`TAS_IDX_W-1:0] idx);
		logic [31:0] w;
		w = `TAS_RST_WORD;
		unique case (idx)
			`TAS_IDX_MULT:   w = s.mult;
			`TAS_IDX_RATE:   w = s.rate_cnt;
			`TAS_IDX_BUDGET: w = s.budget;
			`TAS_IDX_REMAIN: w = s.remaining;
			`TAS_IDX_CTRL:
			begin
				w[`TAS_CTRL_EN]   = (s.phase != tas_pkg::TAS_OFF);
				w[`TAS_CTRL_S1]   = (s.phase == tas_pkg::TAS_FIRST) || (s.phase == tas_pkg::TAS_RUN);
				w[`TAS_CTRL_S2]   = (s.phase == tas_pkg::TAS_RUN);
				w[`TAS_CTRL_CONT] = (s.phase == tas_pkg::TAS_RUN) && (s.budget == `TAS_RST_WORD);
				w[`TAS_CTRL_ENC_MSB:`TAS_CTRL_ENC_LSB] = s.enc_en;
			end
			default:         w = `TAS_RST_WORD;
		endcase
		read_word = w;
	endfunction

	////////////////////////////////////////////////////////////////////////////////

	always_comb
	begin
		next_st = st;
		next_st.hreadyout   = 1'b1;
		next_st.hresp       = 1'b0;
		next_st.packet_push = 1'b0;

		// Time base: a 2 us tick, then a period of (multiplier + 1) ticks.
		base_tick      = (st.base_cnt == tick_last);
		next_st.base_cnt = base_tick ? '0 : st.base_cnt + `TAS_TICK_CNT_W'(1);
		// Using >= means a lowered multiplier ends the current period at the next base tick.
		period_tick = base_tick && (st.period_cnt >= st.mult);
		if (base_tick)
		begin
			next_st.period_cnt = period_tick ? 32'h0000_0000 : st.period_cnt + 32'h0000_0001;
		end
		if (period_tick)
		begin
			next_st.rate_cnt = st.rate_cnt + 32'h0000_0001;
		end

		// Sampling: one packet per period while the second stage holds.
		if (period_tick && st.phase == tas_pkg::TAS_RUN)
		begin
			next_st.packet_push      = 1'b1;
			next_st.packet_timestamp = st.rate_cnt + 32'h0000_0001;
			next_st.packet_encoder   = encoder_data;
			next_st.packet_digital   = digital_in;
			next_st.packet_adc       = adc_data;
			if (!st.cont)
			begin
				next_st.remaining = st.remaining - 32'h0000_0001;
				if (st.remaining == 32'h0000_0001)
				begin
					next_st.phase = tas_pkg::TAS_OFF;
				end
			end
		end

		// Start logic: the single-stage sources skip straight to running.
		single_src = adc_trigger || pwm_trigger || (|(encoder_event & st.enc_en));
		unique case (st.phase)
			tas_pkg::TAS_OFF:
			begin
				next_st.phase = st.phase;
			end
			tas_pkg::TAS_ARMED:
			begin
				if (single_src || first_stage_trigger)
				begin
					next_st.remaining = (st.budget == `TAS_RST_WORD) ? `TAS_ALL_ONES : st.budget;
					next_st.cont      = (st.budget == `TAS_RST_WORD);
					next_st.rate_cnt  = 32'h0000_0000;
					next_st.phase     = single_src ? tas_pkg::TAS_RUN : tas_pkg::TAS_FIRST;
				end
			end
			tas_pkg::TAS_FIRST:
			begin
				if (single_src)
				begin
					next_st.remaining = (st.budget == `TAS_RST_WORD) ? `TAS_ALL_ONES : st.budget;
					next_st.cont      = (st.budget == `TAS_RST_WORD);
					next_st.rate_cnt  = 32'h0000_0000;
					next_st.phase     = tas_pkg::TAS_RUN;
				end
				else if (second_stage_trigger)
				begin
					next_st.phase = tas_pkg::TAS_RUN;
				end
			end
			tas_pkg::TAS_RUN:
			begin
				next_st.phase = next_st.phase;
			end
		endcase

		// Bus data phase: writes land one cycle after their address phase.
		if (st.wr_valid)
		begin
			unique case (st.wr_index)
				`TAS_IDX_MULT:   next_st.mult = hwdata;
				`TAS_IDX_RATE:   next_st.rate_cnt = 32'h0000_0000;
				`TAS_IDX_BUDGET: next_st.budget = hwdata;
				`TAS_IDX_CTRL:
				begin
					next_st.enc_en = hwdata[`TAS_CTRL_ENC_MSB:`TAS_CTRL_ENC_LSB];
					if (!hwdata[`TAS_CTRL_EN])
					begin
						next_st.phase = tas_pkg::TAS_OFF;
					end
					else if (st.phase == tas_pkg::TAS_OFF || next_st.phase == tas_pkg::TAS_OFF)
					begin
						next_st.phase = tas_pkg::TAS_ARMED;
					end
				end
				default:         next_st.wr_valid = 1'b0;
			endcase
		end

		// Bus address phase: zero wait states, reads sampled here.
		accept           = hsel && htrans[1] && hready;
		addr_idx         = word_index(haddr);
		next_st.wr_valid = accept && hwrite;
		next_st.wr_index = addr_idx;
		if (accept && !hwrite)
		begin
			next_st.hrdata = read_word(st, addr_idx);
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			st <= '0;
		end
		else
		begin
			st <= next_st;
		end
	end

	assign hreadyout        = st.hreadyout;
	assign hresp            = st.hresp;
	assign hrdata           = st.hrdata;
	assign packet_push      = st.packet_push;
	assign packet_timestamp = st.packet_timestamp;
	assign packet_encoder   = st.packet_encoder;
	assign packet_digital   = st.packet_digital;
	assign packet_adc       = st.packet_adc;

	////////////////////////////////////////////////////////////////////////////////

	default clocking tas_cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	logic rate_wr;
	logic running;
	logic start_load;
	assign rate_wr = st.wr_valid && (st.wr_index == `TAS_IDX_RATE);
	assign running = (st.phase == tas_pkg::TAS_RUN);
	assign start_load = ((st.phase == tas_pkg::TAS_ARMED) && (single_src || first_stage_trigger)) ||
		((st.phase == tas_pkg::TAS_FIRST) && single_src);

	base_tick_period_a: assert property (base_tick |-> ##tick_cycles base_tick)
		else $error("Base tick is not every 2 us.");

	short_period_a: assert property ((period_tick && st.mult == 32'h0 && !st.wr_valid) |-> ##tick_cycles
		(period_tick || st.mult != 32'h0))
		else $error("Zero multiplier does not give a 2 us period.");

	rate_clear_wr_a: assert property (rate_wr |=> st.rate_cnt == 32'h0)
		else $error("Rate counter write did not clear it.");

	first_load_a: assert property ((st.phase == tas_pkg::TAS_ARMED && first_stage_trigger &&
		!single_src && !st.wr_valid) |=> st.phase == tas_pkg::TAS_FIRST && st.rate_cnt == 32'h0 &&
		st.remaining == (($past(st.budget) == 32'h0) ? 32'hFFFF_FFFF : $past(st.budget)))
		else $error("First stage did not load remaining and clear counter.");

	count_down_a: assert property ((running && period_tick && !st.cont && !st.wr_valid)
		|=> packet_push && st.remaining == $past(st.remaining) - 32'h1)
		else $error("Remaining did not drop by one with a packet.");

	unlimited_hold_a: assert property ((running && st.cont) |=> st.remaining == 32'hFFFF_FFFF)
		else $error("Unlimited capture changed remaining.");

	auto_stop_a: assert property ((running && period_tick && !st.cont && st.remaining == 32'h1 &&
		!st.wr_valid) |=> st.phase == tas_pkg::TAS_OFF ##1 !packet_push[*8])
		else $error("Capture did not stop at zero remaining.");

	single_stage_a: assert property ((st.phase == tas_pkg::TAS_ARMED && (adc_trigger || pwm_trigger) &&
		!st.wr_valid) |=> running)
		else $error("Single-stage source did not set both stages.");

	run_ignore_a: assert property ((running && (single_src || first_stage_trigger) &&
		!period_tick && !rate_wr) |=> st.rate_cnt == $past(st.rate_cnt))
		else $error("Event trigger acted while running.");

	enc_mask_a: assert property ((st.phase == tas_pkg::TAS_ARMED && !adc_trigger && !pwm_trigger &&
		!first_stage_trigger && (encoder_event & st.enc_en) == '0 && !st.wr_valid)
		|=> st.phase == tas_pkg::TAS_ARMED)
		else $error("Masked encoder event started capture.");

	stage_order_a: assert property ($rose(running) |-> $past(st.phase) == tas_pkg::TAS_ARMED ||
		$past(st.phase) == tas_pkg::TAS_FIRST)
		else $error("Second stage rose without first stage.");

	cont_read_a: assert property ((accept && !hwrite && addr_idx == `TAS_IDX_CTRL) |=>
		hrdata[`TAS_CTRL_CONT] == ($past(running) && $past(st.budget) == 32'h0))
		else $error("Continuous bit reads wrong.");

	disabled_idle_a: assert property ((st.phase == tas_pkg::TAS_OFF) |=> st.phase != tas_pkg::TAS_FIRST && !running)
		else $error("Trigger acted while disabled.");

	// The bus check skips the first edge after reset, while the registered hreadyout is still low.
	bus_okay_a: assert property ($past(hresetn) |-> hreadyout && !hresp)
		else $error("Slave stalled or answered with error.");

	mult_write_a: assert property ((st.wr_valid && st.wr_index == `TAS_IDX_MULT)
		|=> st.mult == $past(hwdata))
		else $error("Multiplier write did not land.");

	budget_write_a: assert property ((st.wr_valid && st.wr_index == `TAS_IDX_BUDGET)
		|=> st.budget == $past(hwdata))
		else $error("Budget write did not land.");

	rate_step_a: assert property ((period_tick && !rate_wr && !start_load)
		|=> st.rate_cnt == $past(st.rate_cnt) + 32'h1)
		else $error("Rate counter did not advance once per period.");

	trigger_clear_a: assert property (start_load |=> st.rate_cnt == 32'h0)
		else $error("Start trigger did not clear the rate counter.");

	packet_data_a: assert property ((running && period_tick) |=> packet_push &&
		packet_encoder == $past(encoder_data) && packet_digital == $past(digital_in) &&
		packet_adc == $past(adc_data))
		else $error("Packet did not capture the sampled inputs.");

	stamp_value_a: assert property ((running && period_tick)
		|=> packet_timestamp == $past(st.rate_cnt) + 32'h1)
		else $error("Packet timestamp is not the advanced rate count.");

	push_gate_a: assert property (!(running && period_tick) |=> !packet_push)
		else $error("Packet pushed outside a running period.");

	second_stage_a: assert property ((st.phase == tas_pkg::TAS_FIRST && second_stage_trigger &&
		!single_src && !st.wr_valid) |=> running && st.remaining == $past(st.remaining))
		else $error("Second stage did not start sampling.");

	first_single_a: assert property ((st.phase == tas_pkg::TAS_FIRST && single_src && !st.wr_valid)
		|=> running && st.rate_cnt == 32'h0)
		else $error("Single-stage source in first stage did not start.");

	disable_clear_a: assert property ((st.wr_valid && st.wr_index == `TAS_IDX_CTRL &&
		!hwdata[`TAS_CTRL_EN]) |=> st.phase == tas_pkg::TAS_OFF)
		else $error("Clearing enable did not stop the sequencer.");

	arm_write_a: assert property ((st.wr_valid && st.wr_index == `TAS_IDX_CTRL && hwdata[`TAS_CTRL_EN] &&
		st.phase == tas_pkg::TAS_OFF) |=> st.phase == tas_pkg::TAS_ARMED)
		else $error("Setting enable did not arm the triggers.");

	enc_write_a: assert property ((st.wr_valid && st.wr_index == `TAS_IDX_CTRL)
		|=> st.enc_en == $past(hwdata[`TAS_CTRL_ENC_MSB:`TAS_CTRL_ENC_LSB]))
		else $error("Encoder enables did not land.");

	rate_read_a: assert property ((accept && !hwrite && addr_idx == `TAS_IDX_RATE)
		|=> hrdata == $past(st.rate_cnt))
		else $error("Rate counter read is not the live count.");

	remain_read_a: assert property ((accept && !hwrite && addr_idx == `TAS_IDX_REMAIN)
		|=> hrdata == $past(st.remaining))
		else $error("Remaining read is not the live value.");

	cont_run_a: assert property ((running && st.cont && !st.wr_valid) |=> running)
		else $error("Unlimited capture stopped on its own.");

	budget_load_a: assert property (start_load |=> st.cont == ($past(st.budget) == 32'h0) &&
		st.remaining == (($past(st.budget) == 32'h0) ? 32'hFFFF_FFFF : $past(st.budget)))
		else $error("Start trigger did not load the budget.");

	first_hold_a: assert property ((st.phase == tas_pkg::TAS_FIRST && !single_src &&
		!second_stage_trigger && !st.wr_valid) |=> st.phase == tas_pkg::TAS_FIRST)
		else $error("First stage left without a second-stage event.");

	remain_hold_a: assert property ((!(running && period_tick) && !start_load)
		|=> st.remaining == $past(st.remaining))
		else $error("Remaining changed outside a load or a period.");

	remain_stop_a: assert property ((running && period_tick && !st.cont && st.remaining == 32'h1)
		|=> st.remaining == 32'h0)
		else $error("Remaining did not reach zero at the last sample.");

	two_stage_c: cover property (st.phase == tas_pkg::TAS_FIRST ##[1:1000] running);
	auto_stop_c: cover property (running ##1 st.phase == tas_pkg::TAS_OFF);
	unlimited_c: cover property (running && st.cont && packet_push);
	enc_start_c: cover property (st.phase == tas_pkg::TAS_ARMED && |(encoder_event & st.enc_en) ##1 running);
	rate_clear_c: cover property (rate_wr ##1 st.rate_cnt == 32'h0);

endmodule

//--- src/tas_defines.svh
`ifndef TAS_DEFINES_SVH
`define TAS_DEFINES_SVH

// Register indices; the byte address is four times the index.
`define TAS_IDX_W            6
`define TAS_IDX_MULT         6'h1E
`define TAS_IDX_RATE         6'h1F
`define TAS_IDX_BUDGET       6'h2B
`define TAS_IDX_REMAIN       6'h2C
`define TAS_IDX_CTRL         6'h2D
`define TAS_IDX_NONE         6'h00

// Acquisition control field positions.
`define TAS_CTRL_EN          0
`define TAS_CTRL_S1          1
`define TAS_CTRL_CONT        2
`define TAS_CTRL_S2          3
`define TAS_CTRL_ENC_LSB     4
`define TAS_CTRL_ENC_MSB     7

// Reset values.
`define TAS_RST_WORD         32'h0000_0000
`define TAS_ALL_ONES         32'hFFFF_FFFF

// Widths and counts.
`define TAS_CHANNELS         4
`define TAS_DIN_W            16
`define TAS_ADC_W            16

// Base tick of 2 us at a 20 ns clock.
`define TAS_BASE_TICK_NS     2000
`define TAS_CLK_NS           20
`define TAS_TICK_CYCLES      (`TAS_BASE_TICK_NS / `TAS_CLK_NS)
`define TAS_TICK_CNT_W       7

`endif

//--- src/tas_pkg.sv
`include "tas_defines.svh"

package tas_pkg;

	typedef enum logic [1:0]
	{
		TAS_OFF,
		TAS_ARMED,
		TAS_FIRST,
		TAS_RUN
	} tas_phase_type;

	typedef struct packed
	{
		logic                                            hreadyout;
		logic                                            hresp;
		logic [31:0]                                     hrdata;
		logic                                            wr_valid;
		logic [`TAS_IDX_W-1:0]                           wr_index;
		logic [`TAS_TICK_CNT_W-1:0]                      base_cnt;
		logic [31:0]                                     period_cnt;
		logic [31:0]                                     mult;
		logic [31:0]                                     rate_cnt;
		logic [31:0]                                     budget;
		logic [31:0]                                     remaining;
		logic                                            cont;
		logic [`TAS_CHANNELS-1:0]                        enc_en;
		tas_phase_type                                   phase;
		logic                                            packet_push;
		logic [31:0]                                     packet_timestamp;
		logic [`TAS_CHANNELS-1:0][31:0]                  packet_encoder;
		logic [`TAS_DIN_W-1:0]                           packet_digital;
		logic [`TAS_CHANNELS-1:0][`TAS_ADC_W-1:0]        packet_adc;
	} tas_state_type;

endpackage

//--- verif/tas_host_model.sv
`timescale 1ns/10ps

// Host-side sink: counts packets and the gap between the last two.
// The block has no back-pressure input, so the host is modelled as never stalling.
module tas_host_model
(
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        packet_push,
	output logic [31:0]      push_count,
	output logic [31:0]      gap
);
	logic [31:0] since;

	////////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			push_count <= 32'h0;
			gap <= 32'h0;
			since <= 32'h0;
		end
		else if (packet_push)
		begin
			push_count <= push_count + 32'h1;
			gap <= since + 32'h1;
			since <= 32'h0;
		end
		else
			since <= since + 32'h1;
	end
endmodule

//--- verif/tb_top.sv
`timescale 1ns/10ps
`include "tas_defines.svh"

module tb_top;
	localparam logic [31:0] a_mult   = {24'h0, `TAS_IDX_MULT, 2'h0};
	localparam logic [31:0] a_rate   = {24'h0, `TAS_IDX_RATE, 2'h0};
	localparam logic [31:0] a_budget = {24'h0, `TAS_IDX_BUDGET, 2'h0};
	localparam logic [31:0] a_remain = {24'h0, `TAS_IDX_REMAIN, 2'h0};
	localparam logic [31:0] a_ctrl   = {24'h0, `TAS_IDX_CTRL, 2'h0};

	logic                                     hclk = 1'b0;
	logic                                     hresetn = 1'b0;
	logic                                     hsel = 1'b0;
	logic [31:0]                              haddr = 32'h0000_0000;
	logic [1:0]                               htrans = 2'h0;
	logic                                     hwrite = 1'b0;
	logic [31:0]                              hwdata = 32'h0000_0000;
	logic                                     hreadyout;
	logic                                     hresp;
	logic [31:0]                              hrdata;
	logic [7:0]                               trg = 8'h00;
	logic [`TAS_CHANNELS-1:0][31:0]           enc_d = 128'h1111_2222_3333_4444_5555_6666_7777_8888;
	logic [`TAS_DIN_W-1:0]                    din = 16'hA5C3;
	logic [`TAS_CHANNELS-1:0][`TAS_ADC_W-1:0] adc_d = 64'h0123_4567_89AB_CDEF;
	logic                                     push;
	logic [31:0]                              stamp;
	logic [`TAS_CHANNELS-1:0][31:0]           p_enc;
	logic [`TAS_DIN_W-1:0]                    p_din;
	logic [`TAS_CHANNELS-1:0][`TAS_ADC_W-1:0] p_adc;
	logic [31:0]                              pcount;
	logic [31:0]                              gap;
	logic [31:0]                              r;
	logic [31:0]                              c0;
	int                                       n_mismatch = 0;
	int                                       check_count = 0;

	always #10 hclk = ~hclk;

	tas_top u_tas_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hresp(hresp), .hrdata(hrdata), .first_stage_trigger(trg[0]), .second_stage_trigger(trg[1]),
		.adc_trigger(trg[2]), .pwm_trigger(trg[3]), .encoder_event(trg[7:4]), .encoder_data(enc_d),
		.digital_in(din), .adc_data(adc_d), .packet_push(push), .packet_timestamp(stamp),
		.packet_encoder(p_enc), .packet_digital(p_din), .packet_adc(p_adc));

	tas_host_model u_tas_host_model (.hclk(hclk), .hresetn(hresetn), .packet_push(push),
		.push_count(pcount), .gap(gap));

	////////////////////////////////////////////////////////////////////////////////
	task final_report;
		$display("Counts: %0d checks, %0d mismatches", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task chk(input logic [127:0] seen, input logic [127:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Every wait is bounded so a stuck slave ends the run instead of hanging it.
	task wait_rdy;
		int n;
		n = 0;
		do
		begin
			@(posedge hclk);
			n++;
		end
		while (hreadyout !== 1'b1 && n < 50);
		if (n >= 50)
		begin
			n_mismatch++;
			final_report();
		end
	endtask

	task xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= w;
		wait_rdy();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		wait_rdy();
		r = hrdata;
	endtask

	task rdc(input logic [31:0] a, input logic [31:0] exp);
		xfer(1'b0, a, 32'h0);
		chk(r, exp);
	endtask

	task fire(input logic [7:0] v);
		@(posedge hclk);
		trg <= v;
		@(posedge hclk);
		trg <= 8'h00;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (100000) @(posedge hclk);
		n_mismatch++;
		final_report();
	end

	initial
	begin
		repeat (16) @(posedge hclk);
		hresetn <= 1'b1;
		repeat (2) @(posedge hclk);
		rdc(a_ctrl, 32'h0);
		rdc(a_remain, 32'h0);
		rdc(32'h0, 32'h0);
		$display("test reset done");
		xfer(1'b1, a_mult, 32'h1);
		rdc(a_mult, 32'h1);
		xfer(1'b1, a_budget, 32'h2);
		fire(8'h01);
		rdc(a_ctrl, 32'h0);
		xfer(1'b1, a_ctrl, 32'h1);
		fire(8'h02);
		rdc(a_ctrl, 32'h1);
		fire(8'h01);
		rdc(a_ctrl, 32'h3);
		rdc(a_remain, 32'h2);
		xfer(1'b0, a_rate, 32'h0);
		chk(r <= 32'h1, 1'b1);
		c0 = pcount;
		fire(8'h02);
		rdc(a_ctrl, 32'hB);
		for (int i = 0; i < 1000 && pcount !== c0 + 32'h2; i++)
			@(posedge hclk);
		if (pcount !== c0 + 32'h2)
		begin
			n_mismatch++;
			final_report();
		end
		chk(gap, 32'h0000_00C8);
		rdc(a_ctrl, 32'h0);
		rdc(a_remain, 32'h0);
		chk(pcount - c0, 32'h2);
		chk(p_enc, enc_d);
		chk(p_din, din);
		chk(p_adc, adc_d);
		xfer(1'b0, a_rate, 32'h0);
		chk(r >= 32'h2, 1'b1);
		chk(stamp, r);
		xfer(1'b1, a_rate, 32'h5A5A_0000);
		xfer(1'b0, a_rate, 32'h0);
		chk(r <= 32'h1, 1'b1);
		$display("test budget run done");
		xfer(1'b1, a_budget, 32'h0);
		// No encoder event is pending when acquisition is enabled.
		xfer(1'b1, a_ctrl, 32'h11);
		fire(8'h20);
		rdc(a_ctrl, 32'h11);
		fire(8'h10);
		rdc(a_ctrl, 32'h1F);
		rdc(a_remain, 32'hFFFF_FFFF);
		c0 = pcount;
		repeat (450) @(posedge hclk);
		fire(8'h04);
		rdc(a_remain, 32'hFFFF_FFFF);
		xfer(1'b0, a_rate, 32'h0);
		chk(r >= 32'h2, 1'b1);
		chk(pcount - c0 >= 32'h2, 1'b1);
		xfer(1'b1, a_ctrl, 32'h10);
		rdc(a_ctrl, 32'h10);
		$display("test continuous done");
		for (int k = 2; k < 4; k++)
		begin
			xfer(1'b1, a_ctrl, 32'h1);
			fire(8'h01 << k);
			rdc(a_ctrl, 32'hF);
			xfer(1'b1, a_ctrl, 32'h0);
		end
		$display("test single stage done");
		final_report();
	end
endmodule
